// ===== rtl/vdac_pkg.sv
// constants, types and field layout of the video converter input front end
//
// How it works
// - a rising strobe edge with blanking and white force both high loads the pixel word into the input register, which holds it until the next load or override.
// - the held word is read as an unsigned binary code, one of 256 gray steps from black to white.
// - a register of all ones gives the reference white level.
// - a register of all zeros gives the reference black level.
// - sync and blanking both low clear the register and pick the sync level.
// - blanking low alone clears the register and picks the blanking level.
// - white force low sets the register to all ones and picks reference white.
// - cursor boost low lifts whatever level is picked by one tenth of the picture span.
// - white force and cursor boost both low set the register to ones and give the top level.
// - an open control input reads as logic 0, that is, as an asserted override.
// - a three-state strap picks a black-to-blanking offset of 10, 20 or 0 IRE.
package vdac_pkg;

    localparam int unsigned PIX_W       = 8;
    localparam int unsigned LOG_DEPTH   = 16;
    localparam int unsigned AVS_ADDR_W  = 5;

    // byte addresses of the register words
    localparam logic [4:0] ADDR_CTRL    = 5'h00;
    localparam logic [4:0] ADDR_STATUS  = 5'h04;
    localparam logic [4:0] ADDR_PIXEL   = 5'h08;
    localparam logic [4:0] ADDR_LOG     = 5'h0c;
    localparam logic [4:0] ADDR_COUNT   = 5'h10;

    // control word fields
    localparam int unsigned CTRL_LOG_EN  = 0;
    localparam int unsigned CTRL_CLR_OVF = 1;
    localparam logic        CTRL_LOG_EN_RST = 1'b0;

    // status word fields
    localparam int unsigned STAT_LEVEL_LSB = 0;
    localparam int unsigned STAT_BOOST     = 3;
    localparam int unsigned STAT_SETUP_LSB = 4;
    localparam int unsigned STAT_OVF       = 6;
    localparam int unsigned STAT_EMPTY     = 7;

    // log word fields
    localparam int unsigned LOG_VALID      = 8;

    localparam logic [7:0]  PIX_ZERO  = 8'h00;
    localparam logic [7:0]  PIX_ONES  = 8'hff;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE   = 32'h0000_0001;

    typedef enum logic [2:0] {
        LVL_PICTURE = 3'h0,
        LVL_BLANK   = 3'h1,
        LVL_SYNC    = 3'h2,
        LVL_WHITE   = 3'h3
    } vdac_level_t;

    // black-to-blanking offset picked by the strap
    typedef enum logic [1:0] {
        SETUP_10IRE = 2'h0,
        SETUP_20IRE = 2'h1,
        SETUP_0IRE  = 2'h2
    } vdac_setup_t;

endpackage

// ===== rtl/vdac_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module vdac_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // pins and filtered result
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else if (ce) begin
            s1 <= d_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // per-bit: a change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    q[i] <= s3[i];
                end
            end
        end
    end
endmodule // vdac_sync

// ===== rtl/vdac_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module vdac_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic         push;
    logic         pop;

    // extra pointer bit tells full from empty
    assign out_valid = (wr_ptr != rd_ptr);
    assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // vdac_fifo

// ===== rtl/vdac_front.sv
// input register, override logic and register slave of the video converter
`timescale 1ns/1ps
module vdac_front
    import vdac_pkg::*;
#(
    parameter int unsigned DEPTH = vdac_pkg::LOG_DEPTH
) (
    // clock, reset, enable
    input  wire logic                            SYS_CLK,
    input  wire logic                            RST_N,
    input  wire logic                            CLK_EN,
    // pixel pins
    input  wire logic [vdac_pkg::PIX_W-1:0]      PIX_DATA,
    input  wire logic                            PIX_STROBE,
    // active-low override pins
    input  wire logic                            SYNC_N,
    input  wire logic                            BLANK_N,
    input  wire logic                            WHITE_N,
    input  wire logic                            BOOST_N,
    // offset strap sense
    input  wire logic                            SETUP_NEG,
    input  wire logic                            SETUP_GND,
    // converter drive
    output logic      [vdac_pkg::PIX_W-1:0]      DAC_CODE,
    output vdac_pkg::vdac_level_t                DAC_LEVEL,
    output logic                                 DAC_BOOST,
    output vdac_pkg::vdac_setup_t                DAC_SETUP,
    // avalon-mm slave
    input  wire logic [vdac_pkg::AVS_ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic                            AVS_READ,
    input  wire logic                            AVS_WRITE,
    input  wire logic [31:0]                     AVS_WRITEDATA,
    input  wire logic [3:0]                      AVS_BYTEENABLE,
    output logic      [31:0]                     AVS_READDATA,
    output logic                                 AVS_WAITREQUEST
);
    import vdac_pkg::*;

    localparam int unsigned SYNC_W = PIX_W + 7;

    logic [SYNC_W-1:0] pins_q;
    logic [PIX_W-1:0]  data_q;
    logic              strobe_q;
    logic              strobe_prev;
    logic              strobe_rise;
    logic              ov_sync;
    logic              ov_blank;
    logic              ov_white;
    logic              ov_boost;
    logic              ov_clear;
    logic              neg_q;
    logic              gnd_q;

    logic [PIX_W-1:0]  pix_reg;
    logic [PIX_W-1:0]  next_pix;
    vdac_level_t       next_level;

    logic              log_en;
    logic              log_ovf;
    logic [31:0]       cap_count;
    logic              log_in_ready;
    logic              log_out_valid;
    logic [PIX_W-1:0]  log_out_data;
    logic              log_push;
    logic              log_pop;

    logic              bus_req;
    logic              bus_ack;
    logic              bus_wr;
    logic              bus_rd;
    logic [31:0]       next_rdata;

    // one synchroniser for all pins keeps them aligned to each other
    vdac_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .ce    (CLK_EN),
        .d_in  ({SETUP_GND, SETUP_NEG, BOOST_N, WHITE_N, BLANK_N, SYNC_N,
                 PIX_STROBE, PIX_DATA}),
        .q     (pins_q)
    );

    assign data_q   = pins_q[PIX_W-1:0];
    assign strobe_q = pins_q[PIX_W];
    // a floating pin settles low, so low means asserted
    assign ov_sync  = !pins_q[PIX_W+1];
    assign ov_blank = !pins_q[PIX_W+2];
    assign ov_white = !pins_q[PIX_W+3];
    assign ov_boost = !pins_q[PIX_W+4];
    assign neg_q    = pins_q[PIX_W+5];
    assign gnd_q    = pins_q[PIX_W+6];

    // sync only acts together with blanking
    assign ov_clear = ov_blank;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            strobe_prev <= 1'b0;
        end else if (CLK_EN) begin
            strobe_prev <= strobe_q;
        end
    end

    assign strobe_rise = strobe_q && !strobe_prev;

    // overrides take priority over the strobe every cycle; a clear beats a
    // set so an illegal mix still gives a known code
    always_comb begin
        next_pix = pix_reg;
        if (ov_clear) begin
            next_pix = PIX_ZERO;
        end else if (ov_white) begin
            next_pix = PIX_ONES;
        end else if (strobe_rise) begin
            next_pix = data_q;
        end
    end

    always_comb begin
        next_level = LVL_PICTURE;
        if (ov_clear && ov_sync) begin
            next_level = LVL_SYNC;
        end else if (ov_clear) begin
            next_level = LVL_BLANK;
        end else if (ov_white) begin
            next_level = LVL_WHITE;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pix_reg <= PIX_ZERO;
        end else if (CLK_EN) begin
            pix_reg <= next_pix;
        end
    end

    // code is straight binary: zero is black, all ones is white
    assign DAC_CODE = pix_reg;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            DAC_LEVEL <= LVL_PICTURE;
            DAC_BOOST <= 1'b0;
        end else if (CLK_EN) begin
            DAC_LEVEL <= next_level;
            DAC_BOOST <= ov_boost;
        end
    end

    // strap is a board tie; following it every cycle means the reset zeros
    // still in the synchroniser right after release never stick
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            DAC_SETUP <= SETUP_10IRE;
        end else if (CLK_EN) begin
            if (neg_q && !gnd_q) begin
                DAC_SETUP <= SETUP_20IRE;
            end else if (gnd_q && !neg_q) begin
                DAC_SETUP <= SETUP_0IRE;
            end else begin
                DAC_SETUP <= SETUP_10IRE;
            end
        end
    end

    // capture log: full fifo drops the word and flags it, strobe cannot stall
    assign log_push = CLK_EN && log_en && strobe_rise && !ov_clear && !ov_white;

    vdac_fifo #(
        .W     (PIX_W),
        .DEPTH (DEPTH)
    ) u_log (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .ce        (CLK_EN),
        .in_valid  (log_push),
        .in_ready  (log_in_ready),
        .in_data   (data_q),
        .out_valid (log_out_valid),
        .out_ready (log_pop),
        .out_data  (log_out_data)
    );

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cap_count <= WORD_ZERO;
        end else if (CLK_EN && strobe_rise && !ov_clear && !ov_white) begin
            cap_count <= cap_count + CNT_ONE;
        end
    end

    // bus: one wait cycle, answer on the second edge of the request
    assign bus_req         = AVS_READ || AVS_WRITE;
    // a frozen block must not answer: the write or the pop would be lost
    assign AVS_WAITREQUEST = bus_req && !(bus_ack && CLK_EN);
    assign bus_wr          = CLK_EN && AVS_WRITE && bus_ack;
    assign bus_rd          = CLK_EN && AVS_READ && bus_ack;
    assign log_pop         = bus_rd && (AVS_ADDRESS == ADDR_LOG);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            bus_ack <= 1'b0;
        end else if (CLK_EN) begin
            bus_ack <= bus_req && !bus_ack;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            log_en <= CTRL_LOG_EN_RST;
        end else if (bus_wr && AVS_ADDRESS == ADDR_CTRL && AVS_BYTEENABLE[0]) begin
            log_en <= AVS_WRITEDATA[CTRL_LOG_EN];
        end
    end

    // a drop in the same cycle as the clear keeps the flag set
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            log_ovf <= 1'b0;
        end else if (CLK_EN) begin
            if (log_push && !log_in_ready) begin
                log_ovf <= 1'b1;
            end else if (bus_wr && AVS_ADDRESS == ADDR_CTRL && AVS_BYTEENABLE[0]
                         && AVS_WRITEDATA[CTRL_CLR_OVF]) begin
                log_ovf <= 1'b0;
            end
        end
    end

    always_comb begin
        next_rdata = WORD_ZERO;
        case (AVS_ADDRESS)
            ADDR_CTRL: begin
                next_rdata[CTRL_LOG_EN] = log_en;
            end
            ADDR_STATUS: begin
                next_rdata[STAT_LEVEL_LSB +: 3] = DAC_LEVEL;
                next_rdata[STAT_BOOST]          = DAC_BOOST;
                next_rdata[STAT_SETUP_LSB +: 2] = DAC_SETUP;
                next_rdata[STAT_OVF]            = log_ovf;
                next_rdata[STAT_EMPTY]          = !log_out_valid;
            end
            ADDR_PIXEL: begin
                next_rdata[PIX_W-1:0] = pix_reg;
            end
            ADDR_LOG: begin
                next_rdata[PIX_W-1:0] = log_out_valid ? log_out_data : PIX_ZERO;
                next_rdata[LOG_VALID] = log_out_valid;
            end
            ADDR_COUNT: begin
                next_rdata = cap_count;
            end
            default: begin
                next_rdata = WORD_ZERO;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            AVS_READDATA <= WORD_ZERO;
        end else if (CLK_EN && AVS_READ && !bus_ack) begin
            AVS_READDATA <= next_rdata;
        end
    end

    chk_capture_word: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && strobe_rise && !ov_clear && !ov_white) |=> (pix_reg == $past(data_q)))
        else $error("strobe edge did not load the pixel word");

    chk_hold_word: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && !strobe_rise && !ov_clear && !ov_white) |=> $stable(pix_reg))
        else $error("input register changed without strobe or override");

    chk_sync_clear: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && ov_sync && ov_blank) |=> (DAC_CODE == PIX_ZERO && DAC_LEVEL == LVL_SYNC))
        else $error("sync with blanking did not clear and pick sync level");

    chk_blank_clear: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && ov_blank && !ov_sync) |=> (pix_reg == PIX_ZERO && DAC_LEVEL == LVL_BLANK))
        else $error("blanking did not clear and pick blanking level");

    chk_white_set: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && ov_white && !ov_clear) |=> (pix_reg == PIX_ONES && DAC_LEVEL == LVL_WHITE))
        else $error("white force did not set register to ones");

    chk_boost_follow: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && ov_boost && !ov_white && !ov_clear) |=>
            (DAC_BOOST && DAC_LEVEL == LVL_PICTURE && pix_reg == $past(next_pix)))
        else $error("boost changed the register or was not flagged");

    chk_cursor_top: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && ov_white && ov_boost && !ov_clear) |=>
            (DAC_BOOST && DAC_LEVEL == LVL_WHITE && DAC_CODE == PIX_ONES))
        else $error("cursor combination did not reach top level");

    chk_strap_pick: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && neg_q && !gnd_q) |=> (DAC_SETUP == SETUP_20IRE))
        else $error("negative strap did not give 20 IRE setup");

    chk_bus_answer: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && bus_req && !bus_ack) ##1 CLK_EN |-> !AVS_WAITREQUEST)
        else $error("bus answer not given on second edge");

    chk_boost_flag: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        CLK_EN |=> (DAC_BOOST == $past(ov_boost)))
        else $error("boost flag does not follow the boost pin");

    chk_picture_level: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && !ov_clear && !ov_white) |=> (DAC_LEVEL == LVL_PICTURE))
        else $error("picture level not picked without overrides");

    chk_strap_ground: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && gnd_q && !neg_q) |=> (DAC_SETUP == SETUP_0IRE))
        else $error("ground strap did not give 0 IRE setup");

    chk_strap_open: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && (gnd_q == neg_q)) |=> (DAC_SETUP == SETUP_10IRE))
        else $error("open strap did not give 10 IRE setup");

    chk_freeze_state: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        !CLK_EN |=> ($stable(pix_reg) && $stable(DAC_LEVEL) && $stable(cap_count)))
        else $error("state moved while clock enable was low");

    chk_wait_frozen: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (!CLK_EN && bus_req) |-> AVS_WAITREQUEST)
        else $error("bus answered while clock enable was low");

    chk_overflow_set: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (log_push && !log_in_ready) |=> log_ovf)
        else $error("dropped capture did not raise overflow");

endmodule // vdac_front

// ===== dv/vdac_pix_src.sv
// pixel source and sync/blank timing model facing the converter front end
`timescale 1ns/1ps
module vdac_pix_src (
    // clock
    input  wire logic       clk,
    // pixel and override pins
    output logic      [7:0] pix_data,
    output logic            pix_strobe,
    output logic            sync_n,
    output logic            blank_n,
    output logic            white_n,
    output logic            boost_n
);
    initial begin
        pix_data   = 8'h00;
        pix_strobe = 1'b0;
        sync_n     = 1'b1;
        blank_n    = 1'b1;
        white_n    = 1'b1;
        boost_n    = 1'b1;
    end

    // data stable four clocks either side of the rise, well inside the sampler's reach
    task automatic send(input logic [7:0] code);
        @(posedge clk);
        pix_data   <= code;
        repeat (4) @(posedge clk);
        pix_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        pix_strobe <= 1'b0;
        pix_data   <= ~code; // released bus no longer shows the word
        repeat (4) @(posedge clk);
    endtask

    // n is {sync, blank, white, boost}, all active low
    task automatic set_ovr(input logic [3:0] n);
        logic [3:0] v;
        v = n;
        if ((!v[3] || !v[2]) && (!v[1] || !v[0])) begin
            v = 4'hf;
        end
        @(posedge clk);
        sync_n  <= v[3];
        blank_n <= v[2];
        white_n <= v[1];
        boost_n <= v[0];
    endtask
endmodule // vdac_pix_src

// ===== dv/vdac_front_bench.sv
// self-checking bench of the converter front end
`timescale 1ns/1ps
module vdac_front_bench;
    import vdac_pkg::*;

    logic        clk;
    logic        rst_n;
    logic        clk_en;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  pix_data;
    logic        pix_strobe;
    logic        sync_n;
    logic        blank_n;
    logic        white_n;
    logic        boost_n;
    logic [7:0]  dac_code;
    vdac_level_t dac_level;
    logic        dac_boost;
    vdac_setup_t dac_setup;
    logic        setup_neg;
    logic        setup_gnd;
    int          err_total;
    int          n_compared;

    vdac_front DUT (
        .SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en),
        .PIX_DATA(pix_data), .PIX_STROBE(pix_strobe),
        .SYNC_N(sync_n), .BLANK_N(blank_n), .WHITE_N(white_n), .BOOST_N(boost_n),
        .SETUP_NEG(setup_neg), .SETUP_GND(setup_gnd),
        .DAC_CODE(dac_code), .DAC_LEVEL(dac_level), .DAC_BOOST(dac_boost),
        .DAC_SETUP(dac_setup),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest)
    );

    vdac_pix_src src (
        .clk(clk), .pix_data(pix_data), .pix_strobe(pix_strobe),
        .sync_n(sync_n), .blank_n(blank_n), .white_n(white_n), .boost_n(boost_n)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // waits on waitrequest only; a hung slave ends the run
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) begin
                err_total++;
                print_verdict();
            end
        end while (avs_waitrequest !== 1'b0);
    endtask

    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read    <= 1'b1;
        bus_wait();
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        bus_wait();
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_dac(input logic [7:0] c, input vdac_level_t l, input logic b);
        int n;
        n = 0;
        while (!(dac_code === c && dac_level === l && dac_boost === b) && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("dac_code", {24'h0, c}, {24'h0, dac_code});
        chk("dac_level", {29'h0, l}, {29'h0, dac_level});
        chk("dac_boost", {31'h0, b}, {31'h0, dac_boost});
        if (n >= 40) begin
            print_verdict();
        end
    endtask

    task automatic t_reset_state();
        logic [31:0] d;
        chk("dac_setup", {30'h0, SETUP_10IRE}, {30'h0, dac_setup});
        wait_dac(PIX_ZERO, LVL_PICTURE, 1'b0);
        bus_rd(ADDR_CTRL, d);
        chk("ctrl", {31'h0, CTRL_LOG_EN_RST}, d);
        bus_wr(5'h14, 32'hffff_ffff);
        bus_rd(5'h14, d);
        chk("unmapped", WORD_ZERO, d);
    endtask

    task automatic t_capture();
        logic [7:0]  codes [5] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h01};
        logic [31:0] d;
        foreach (codes[i]) begin
            src.send(codes[i]);
            wait_dac(codes[i], LVL_PICTURE, 1'b0);
            bus_rd(ADDR_PIXEL, d);
            chk("pixel", {24'h0, codes[i]}, {24'h0, d[7:0]});
        end
    endtask

    task automatic ovr_case(input logic [3:0] n, input logic [7:0] c,
                            input vdac_level_t l, input logic b);
        logic [31:0] d;
        src.set_ovr(n);
        wait_dac(c, l, b);
        bus_rd(ADDR_STATUS, d);
        chk("status_level", {28'h0, b, l}, {28'h0, d[3:0]});
    endtask

    task automatic t_override();
        src.send(8'h40);
        ovr_case(4'b1011, PIX_ZERO, LVL_BLANK, 1'b0);
        ovr_case(4'b0011, PIX_ZERO, LVL_SYNC, 1'b0);
        ovr_case(4'b1111, PIX_ZERO, LVL_PICTURE, 1'b0);
        ovr_case(4'b1101, PIX_ONES, LVL_WHITE, 1'b0);
        ovr_case(4'b1111, PIX_ONES, LVL_PICTURE, 1'b0);
        src.send(8'h40);
        ovr_case(4'b1110, 8'h40, LVL_PICTURE, 1'b1);
        ovr_case(4'b1100, PIX_ONES, LVL_WHITE, 1'b1);
        ovr_case(4'b1111, PIX_ONES, LVL_PICTURE, 1'b0);
    endtask

    // strap is a static tie; the block follows it through the synchroniser
    task automatic t_strap();
        logic [31:0] d;
        setup_neg <= 1'b1;
        repeat (8) @(posedge clk);
        chk("setup_neg", {30'h0, SETUP_20IRE}, {30'h0, dac_setup});
        setup_neg <= 1'b0;
        setup_gnd <= 1'b1;
        repeat (8) @(posedge clk);
        bus_rd(ADDR_STATUS, d);
        chk("setup_gnd", {30'h0, SETUP_0IRE}, {30'h0, d[STAT_SETUP_LSB +: 2]});
        setup_gnd <= 1'b0;
        repeat (8) @(posedge clk);
        chk("setup_open", {30'h0, SETUP_10IRE}, {30'h0, dac_setup});
    endtask

    // clock enable low: nothing moves and a pending read stalls
    task automatic t_freeze();
        logic [31:0] d;
        @(posedge clk);
        clk_en      <= 1'b0;
        avs_address <= ADDR_PIXEL;
        avs_read    <= 1'b1;
        src.set_ovr(4'b1011);
        repeat (10) @(posedge clk);
        chk("frozen_wait", 32'h1, {31'h0, avs_waitrequest});
        chk("frozen_code", {24'h0, PIX_ONES}, {24'h0, dac_code});
        chk("frozen_level", {29'h0, LVL_PICTURE}, {29'h0, dac_level});
        clk_en <= 1'b1;
        bus_wait();
        d = avs_readdata;
        avs_read <= 1'b0;
        chk("frozen_read", {24'h0, PIX_ONES}, d);
        wait_dac(PIX_ZERO, LVL_BLANK, 1'b0);
        src.set_ovr(4'b1111);
        wait_dac(PIX_ZERO, LVL_PICTURE, 1'b0);
    endtask

    // seventeen captures into a sixteen-deep log: the last one must be dropped
    task automatic t_log();
        logic [31:0] base;
        logic [31:0] d;
        bus_rd(ADDR_COUNT, base);
        bus_wr(ADDR_CTRL, CNT_ONE);
        for (int i = 0; i < 17; i++) begin
            src.send(8'h10 + 8'(i));
        end
        bus_rd(ADDR_COUNT, d);
        chk("count", base + 32'd17, d);
        bus_rd(ADDR_STATUS, d);
        chk("overflow", 32'h1, {31'h0, d[STAT_OVF]});
        for (int i = 0; i < 16; i++) begin
            bus_rd(ADDR_LOG, d);
            chk("log", {23'h0, 1'b1, 8'h10 + 8'(i)}, d);
        end
        bus_rd(ADDR_STATUS, d);
        chk("empty", 32'h1, {31'h0, d[STAT_EMPTY]});
        bus_rd(ADDR_LOG, d);
        chk("log_valid", WORD_ZERO, {31'h0, d[LOG_VALID]});
        bus_wr(ADDR_CTRL, 32'h0000_0002);
        bus_rd(ADDR_STATUS, d);
        chk("ovf_clear", WORD_ZERO, {31'h0, d[STAT_OVF]});
    endtask

    initial begin
        err_total      = 0;
        n_compared     = 0;
        rst_n          = 1'b0;
        clk_en         = 1'b1;
        avs_address    = 5'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hf;
        setup_neg      = 1'b0;
        setup_gnd      = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // synchronisers start at zero and read as overrides until flushed
        repeat (8) @(posedge clk);
        t_reset_state();
        t_strap();
        t_capture();
        t_override();
        t_freeze();
        t_log();
        print_verdict();
    end
endmodule // vdac_front_bench
